// ==== dv/host_master.sv ====
// host-side two-wire master model
`timescale 1ns/1ps
module host_master #(
  parameter int unsigned T_BUF_NS = 1000 // bus free after stop
) (
  input wire logic scl_w, // clock wire level
  input wire logic sda_w, // data wire level
  output logic scl_h, // clock drive, 1 releases
  output logic sda_h // data drive, 1 releases
);
  int to = 0;
  initial begin
    scl_h = 1'b1;
    sda_h = 1'b1;
  end
  // release clock, then wait out stretching under a bound
  task automatic rise();
    scl_h = 1'b1;
    for (int i = 0; i < 60000 && !scl_w; i++) #10;
    if (!scl_w) to++;
    #40;
  endtask : rise
  task automatic bit_io(input logic b, output logic r);
    #20 sda_h = b;
    #20 rise();
    r = sda_w;
    scl_h = 1'b0;
  endtask : bit_io
  task automatic start();
    #(T_BUF_NS);
    #20 sda_h = 1'b1;
    #20 rise();
    sda_h = 1'b0;
    #40 scl_h = 1'b0;
  endtask : start
  task automatic stop();
    #20 sda_h = 1'b0;
    #20 rise();
    sda_h = 1'b1;
    #(T_BUF_NS);
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(m, r);
    a = !r;
  endtask : xfer
endmodule : host_master

// ==== dv/mgmt_chk.sv ====
// port assertions for the module management block
`timescale 1ns/1ps
module mgmt_chk #(
  parameter int unsigned INIT_CYC = 20
) (
  input wire logic ref_clk, // block clock
  input wire logic rst, // synchronous reset
  input wire logic scl_in, // clock wire
  input wire logic scl_out, // clock drive value
  input wire logic scl_oe, // clock pull enable
  input wire logic sda_in, // data wire
  input wire logic sda_out, // data drive value
  input wire logic sda_oe, // data pull enable
  input wire logic bus_select_n, // host select
  input wire logic rx_power_low, // power too low
  input wire logic transmitter_off_request, // disable input
  input wire logic rx_power_lost, // loss indication
  input wire logic module_missing, // presence line
  input wire logic tx_enable, // transmitter enable
  input wire logic init_done // init finished
);
  import mgmt_pkg::*;
  int lo_c, hi_c, on_c, st_c, in_c;
  // raw-input run lengths; the sync flops add delay: margin for the minimum checks, less slack for the maximum ones
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lo_c <= 0;
      hi_c <= 0;
      on_c <= 0;
      st_c <= 0;
      in_c <= 0;
    end else begin
      lo_c <= rx_power_low ? lo_c + 1 : 0;
      hi_c <= rx_power_low ? 0 : hi_c + 1;
      on_c <= (!transmitter_off_request && init_done) ? on_c + 1 : 0;
      st_c <= scl_oe ? st_c + 1 : 0;
      in_c <= in_c + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  present_low_a: assert property (!module_missing)
    else $error("presence line high");
  loss_min_a: assert property ($rose(rx_power_lost) |-> lo_c >= 50)
    else $error("loss raised too early");
  loss_max_a: assert property (lo_c >= 60 |-> rx_power_lost)
    else $error("loss not raised");
  clear_min_a: assert property ($fell(rx_power_lost) |-> hi_c >= 50)
    else $error("loss cleared too early");
  clear_max_a: assert property (hi_c >= 60 |-> !rx_power_lost)
    else $error("loss not cleared");
  tx_off_a: assert property (transmitter_off_request [*8] |-> !tx_enable)
    else $error("transmitter still on");
  tx_on_a: assert property (on_c >= 120 |-> tx_enable)
    else $error("transmitter not on");
  init_time_a: assert property ($rose(init_done) |->
    in_c + 1 >= INIT_CYC && in_c <= INIT_CYC + 1)
    else $error("init time wrong");
  init_quiet_a: assert property (!init_done |-> !tx_enable && !sda_oe)
    else $error("active before init");
  sel_idle_a: assert property (bus_select_n [*8] |-> !sda_oe && !scl_oe)
    else $error("lines held while deselected");
  stretch_max_a: assert property (st_c <= STRETCH_MAX_CYC)
    else $error("clock stretched too long");
  drive_low_a: assert property (!scl_out && !sda_out)
    else $error("drive value not low");
  cover property ($rose(sda_oe));
  cover property ($rose(scl_oe));
  cover property ($rose(rx_power_lost));
  cover property ($fell(tx_enable));
endmodule : mgmt_chk

bind module_mgmt_two_wire_alarms mgmt_chk #(.INIT_CYC(INIT_CYC)) i_chk (
  .ref_clk, .rst, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
  .bus_select_n, .rx_power_low, .transmitter_off_request, .rx_power_lost,
  .module_missing, .tx_enable, .init_done);

// ==== dv/tb_top.sv ====
// self-checking bench for the module management block
`timescale 1ns/1ps
module tb_top;
  import mgmt_pkg::*;
  localparam int SEL_NS = 2000; // select setup and hold, shortened
  logic ref_clk, rst, scl_out, scl_oe, sda_out, sda_oe, bus_select_n;
  logic rx_power_low, transmitter_off_request, rx_power_lost;
  logic module_missing, tx_enable, init_done, scl_h, sda_h, a;
  logic [7:0] q, p, d;
  int errors = 0;
  int n_tests = 0;
  int mem [128];
  logic [31:0] seed = 32'h0000_f13b;
  wire logic scl_in = scl_h & ~(scl_oe & ~scl_out);
  wire logic sda_in = sda_h & ~(sda_oe & ~sda_out);
  module_mgmt_two_wire_alarms #(.INIT_CYC(20)) i_dut (.ref_clk, .rst,
    .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .bus_select_n,
    .rx_power_low, .transmitter_off_request, .rx_power_lost,
    .module_missing, .tx_enable, .init_done);
  host_master i_host (.scl_w(scl_in), .sda_w(sda_in), .scl_h, .sda_h);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop();
    errors += i_host.to;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic addr(input logic [7:0] b, input logic e);
    i_host.start();
    i_host.xfer(b, 1'b1, q, a);
    chk(a, e);
  endtask : addr
  task automatic wr(input logic [7:0] pt, input logic [7:0] v);
    addr(8'ha0, 1'b1);
    i_host.xfer(pt, 1'b1, q, a);
    chk(a, 1'b1);
    i_host.xfer(v, 1'b1, q, a);
    chk(a, 1'b1);
    i_host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] pt, input logic [7:0] e);
    addr(8'ha0, 1'b1);
    i_host.xfer(pt, 1'b1, q, a);
    addr(8'ha1, 1'b1);
    i_host.xfer(8'hff, 1'b1, q, a);
    chk(q, e);
    i_host.stop();
  endtask : rd
  task automatic lvl(input logic v, input logic was);
    rx_power_low = v;
    cyc(45);
    chk(rx_power_lost, was);
    cyc(25);
    chk(rx_power_lost, v);
  endtask : lvl
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #500us;
    errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    bus_select_n = 1'b1;
    rx_power_low = 1'b0;
    transmitter_off_request = 1'b0;
    cyc(3);
    rst = 1'b0;
    chk(module_missing, 1'b0);
    for (int i = 0; i < 100 && init_done !== 1'b1; i++) cyc(1);
    chk(init_done, 1'b1);
    addr(8'ha0, 1'b0);
    i_host.stop();
    cyc(1);
    bus_select_n = 1'b0;
    #(SEL_NS);
    addr(8'ha2, 1'b0);
    i_host.stop();
    // last pass lands in the nonvolatile region and is stretched
    for (int k = 0; k < 4; k++) begin
      p = (k == 3) ? NV_BASE + 8'(rnd() % 64) : 8'(rnd() % 62);
      d = 8'(rnd());
      wr(p, d);
      mem[p] = d;
      rd(p, 8'(mem[p]));
    end
    wr(8'h3e, 8'h00);
    rd(8'h3e, ALT_SETUP_VAL);
    rd(8'h3f, ALT_HOLD_VAL);
    #(SEL_NS);
    // deselect while the ack is driven: the host then reads no ack
    fork
      addr(8'ha0, 1'b0);
      begin
        for (int i = 0; i < 2000 && sda_oe !== 1'b1; i++) cyc(1);
        chk(sda_oe, 1'b1);
        bus_select_n = 1'b1;
        cyc(8);
        chk(sda_oe, 1'b0);
      end
    join
    i_host.stop();
    rx_power_low = 1'b1;
    cyc(20);
    lvl(1'b0, 1'b0);
    lvl(1'b1, 1'b0);
    lvl(1'b0, 1'b1);
    chk(tx_enable, 1'b1);
    transmitter_off_request = 1'b1;
    cyc(10);
    chk(tx_enable, 1'b0);
    transmitter_off_request = 1'b0;
    cyc(120);
    chk(tx_enable, 1'b1);
    report_and_stop();
  end
endmodule : tb_top

// ==== hw/level_settle.sv ====
// level filter that moves its output after a settled run of cycles
`timescale 1ns/1ps
module level_settle #(
  parameter int unsigned RISE_CYC = 1,
  parameter int unsigned FALL_CYC = 1
) (
  input wire logic ref_clk, // block clock
  input wire logic rst, // synchronous reset, active high
  input wire logic reset_level, // level held during reset
  input wire logic level_in, // synchronised level
  output logic level_out // settled level
);
  logic [31:0] run_reg;
  logic [31:0] need;

  assign need = level_out ? FALL_CYC : RISE_CYC;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_reg <= 32'h0000_0000;
    end else if (level_in == level_out || run_reg + 32'h0000_0001 >= need) begin
      run_reg <= 32'h0000_0000;
    end else begin
      run_reg <= run_reg + 32'h0000_0001;
    end
  end

  // output only flips once the input has differed for the whole run
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_out <= reset_level;
    end else if (level_in != level_out &&
                 run_reg + 32'h0000_0001 >= need) begin
      level_out <= level_in;
    end
  end
endmodule : level_settle

// ==== hw/mgmt_pkg.sv ====
// constants and carrier types for the module management block
package mgmt_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [6:0] TARGET_ADDR = 7'h50;
  // time figures in their own units
  localparam int unsigned LOSS_MIN_NS = 500;
  localparam int unsigned LOSS_MAX_US = 400;
  localparam int unsigned TX_OFF_MAX_US = 100;
  localparam int unsigned TX_ON_MAX_S = 25;
  localparam int unsigned INIT_MIN_S = 19;
  localparam int unsigned INIT_MAX_S = 120;
  localparam int unsigned STRETCH_MAX_US = 500;
  localparam int unsigned COMMIT_NS = 2000;
  localparam int unsigned TX_SETTLE_NS = 1000;
  // derived cycle counts
  localparam int unsigned LOSS_MIN_CYC =
    (LOSS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRETCH_MAX_CYC =
    STRETCH_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned COMMIT_CYC =
    (COMMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TX_SETTLE_CYC =
    (TX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_MIN_CYC = INIT_MIN_S * CLK_HZ;
  // register map of the management space
  localparam int MEM_DEPTH = 128;
  localparam logic [6:0] NV_BASE = 7'h40;
  localparam logic [6:0] ALT_SETUP_OFS = 7'h3e;
  localparam logic [6:0] ALT_HOLD_OFS = 7'h3f;
  // alternative select times in units of 0.1 ms
  localparam logic [7:0] ALT_SETUP_VAL = 8'h14;
  localparam logic [7:0] ALT_HOLD_VAL = 8'h14;
  localparam logic [7:0] MEM_RESET_VAL = 8'h00;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sel_n;
    logic rx_low;
    logic tx_off;
  } pin_sample_t;

  localparam pin_sample_t PIN_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0011,
    ST_PTR = 4'b0010,
    ST_PTR_ACK = 4'b0110,
    ST_WDATA = 4'b0111,
    ST_WACK = 4'b0101,
    ST_RDATA = 4'b1101,
    ST_RACK = 4'b1111
  } bus_state_t;
endpackage : mgmt_pkg

// ==== hw/module_mgmt_two_wire_alarms.sv ====
// management target, alarm outputs and transmitter control of the module
`timescale 1ns/1ps
module module_mgmt_two_wire_alarms #(
  parameter int unsigned INIT_CYC = mgmt_pkg::INIT_MIN_CYC
) (
  input wire logic ref_clk, // 100 MHz block clock
  input wire logic rst, // synchronous reset, active high
  input wire logic scl_in, // serial clock level seen on the pin
  output logic scl_out, // serial clock drive value, always low
  output logic scl_oe, // high while stretching the clock
  input wire logic sda_in, // serial data level seen on the pin
  output logic sda_out, // serial data drive value, always low
  output logic sda_oe, // high while pulling data low
  input wire logic bus_select_n, // host select, low selects
  input wire logic rx_power_low, // optical front end: power too low
  input wire logic transmitter_off_request, // host disable input
  output logic rx_power_lost, // receive loss indication
  output logic module_missing, // presence line, low when inserted
  output logic tx_enable, // transmitter drive enable
  output logic init_done // initialization finished
);
  import mgmt_pkg::*;

  pin_sample_t meta_reg, sync_reg;
  logic scl_prev_reg, sda_prev_reg;
  bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_byte_reg;
  logic [6:0] ptr_reg;
  logic [31:0] init_cnt_reg;
  logic [31:0] stretch_cnt_reg;
  logic nv_write_reg;
  logic los_settled, tx_settled;
  logic [7:0] rd_cur, rd_nxt;
  logic [7:0] mem [MEM_DEPTH];

  logic scl_rise, scl_fall, start_seen, stop_seen, selected;

  // read view: fixed capability bytes overlay the store
  function automatic logic [7:0] read_byte(input logic [6:0] ofs,
                                           input logic [7:0] stored);
    unique case (ofs)
      ALT_SETUP_OFS: read_byte = ALT_SETUP_VAL;
      ALT_HOLD_OFS: read_byte = ALT_HOLD_VAL;
      default: read_byte = stored;
    endcase
  endfunction : read_byte

  // bytes at the pointer and one past it, as the host will see them
  always_comb begin
    rd_cur = read_byte(ptr_reg, mem[ptr_reg]);
    rd_nxt = read_byte(ptr_reg + 7'h01, mem[ptr_reg + 7'h01]);
  end

  // two flops before any logic looks at a pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= PIN_IDLE;
      sync_reg <= PIN_IDLE;
    end else begin
      meta_reg <= '{scl_in, sda_in, bus_select_n, rx_power_low,
                    transmitter_off_request};
      // many samples per clock phase even at the 1 MHz bus rate
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= sync_reg.scl;
      sda_prev_reg <= sync_reg.sda;
    end
  end

  assign scl_rise = sync_reg.scl & ~scl_prev_reg;
  assign scl_fall = ~sync_reg.scl & scl_prev_reg;
  assign start_seen = sync_reg.scl & scl_prev_reg &
                      ~sync_reg.sda & sda_prev_reg;
  assign stop_seen = sync_reg.scl & scl_prev_reg &
                     sync_reg.sda & ~sda_prev_reg;
  // select high is the pulled-up idle: no bus activity at all
  assign selected = ~sync_reg.sel_n & init_done;

  // initialization timer from reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      init_cnt_reg <= 32'h0000_0000;
      init_done <= 1'b0;
    end else if (!init_done) begin
      if (init_cnt_reg + 32'h0000_0001 >= INIT_CYC) begin
        init_done <= 1'b1;
      end else begin
        init_cnt_reg <= init_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // loss filter: settled run keeps glitches shorter than the minimum out
  level_settle #(
    .RISE_CYC(LOSS_MIN_CYC),
    .FALL_CYC(LOSS_MIN_CYC)
  ) los_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .reset_level(1'b0),
    .level_in(sync_reg.rx_low),
    .level_out(los_settled)
  );

  // transmitter: off on the synchronised request at once, on after settling
  level_settle #(
    .RISE_CYC(TX_SETTLE_CYC),
    .FALL_CYC(1)
  ) tx_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .reset_level(1'b0),
    .level_in(~sync_reg.tx_off & init_done),
    .level_out(tx_settled)
  );

  // alarm outputs registered so the pins come straight from flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_power_lost <= 1'b0;
      tx_enable <= 1'b0;
    end else begin
      rx_power_lost <= los_settled;
      tx_enable <= tx_settled & ~sync_reg.tx_off;
    end
  end

  // presence: a flop held low stands in for the internal pull-down
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      module_missing <= 1'b0;
    end else begin
      module_missing <= 1'b0;
    end
  end

  // open drain: only the enables move, the drive value stays low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // clock stretch after a nonvolatile byte, bounded well below the limit
  // a deselect cuts a stretch short and frees the clock line
  always_ff @(posedge ref_clk) begin
    if (rst || !selected) begin
      stretch_cnt_reg <= 32'h0000_0000;
      scl_oe <= 1'b0;
    end else if (state_reg == ST_WACK && scl_fall && nv_write_reg) begin
      stretch_cnt_reg <= COMMIT_CYC;
      scl_oe <= 1'b1;
    end else if (stretch_cnt_reg != 32'h0000_0000) begin
      stretch_cnt_reg <= stretch_cnt_reg - 32'h0000_0001;
      scl_oe <= stretch_cnt_reg != 32'h0000_0001;
    end else begin
      scl_oe <= 1'b0;
    end
  end

  // bit counter and receive shifter
  // a start clears the count so a repeated start realigns bytes
  always_ff @(posedge ref_clk) begin
    if (rst || !selected || start_seen) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (scl_rise) begin
      shift_reg <= {shift_reg[6:0], sync_reg.sda};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end else if (scl_fall && bit_cnt_reg == 4'h9) begin
      bit_cnt_reg <= 4'h0;
    end
  end

  // volatile writes land in one cycle, so acceptance is immediate
  always_ff @(posedge ref_clk) begin
    if (selected && state_reg == ST_WDATA && scl_fall &&
        bit_cnt_reg == 4'h8) begin
      mem[ptr_reg] <= shift_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nv_write_reg <= 1'b0;
    end else if (state_reg == ST_WDATA && scl_fall &&
                 bit_cnt_reg == 4'h8) begin
      nv_write_reg <= ptr_reg >= NV_BASE;
    end
  end

  // byte pointer: set by the first written byte, steps per data byte
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr_reg <= 7'h00;
    end else if (selected && scl_fall && bit_cnt_reg == 4'h8) begin
      if (state_reg == ST_PTR) begin
        ptr_reg <= shift_reg[6:0];
      end else if (state_reg == ST_WDATA) begin
        ptr_reg <= ptr_reg + 7'h01;
      end
    end else if (selected && scl_fall && state_reg == ST_RACK &&
                 bit_cnt_reg == 4'h9) begin
      ptr_reg <= ptr_reg + 7'h01;
    end
  end

  // sequencer and data line drive
  // deselect drops an ack at once, even in mid-byte
  always_ff @(posedge ref_clk) begin
    if (rst || !selected) begin
      state_reg <= ST_IDLE;
      sda_oe <= 1'b0;
      tx_byte_reg <= 8'h00;
    end else if (stop_seen) begin
      state_reg <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_seen) begin
      state_reg <= ST_ADDR;
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_ADDR: begin
          if (bit_cnt_reg == 4'h8) begin
            if (shift_reg[7:1] == TARGET_ADDR) begin
              state_reg <= ST_ADDR_ACK;
              sda_oe <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          // the ack clock has shifted in, so the direction bit sits at 1
          if (shift_reg[1]) begin
            state_reg <= ST_RDATA;
            tx_byte_reg <= {rd_cur[6:0], 1'b0};
            sda_oe <= ~rd_cur[7];
          end else begin
            state_reg <= ST_PTR;
            sda_oe <= 1'b0;
          end
        end
        ST_PTR: begin
          if (bit_cnt_reg == 4'h8) begin
            state_reg <= ST_PTR_ACK;
            sda_oe <= 1'b1;
          end
        end
        ST_PTR_ACK, ST_WACK: begin
          state_reg <= ST_WDATA;
          sda_oe <= 1'b0;
        end
        ST_WDATA: begin
          if (bit_cnt_reg == 4'h8) begin
            state_reg <= ST_WACK;
            sda_oe <= 1'b1;
          end
        end
        ST_RDATA: begin
          if (bit_cnt_reg == 4'h8) begin
            state_reg <= ST_RACK;
            sda_oe <= 1'b0;
          end else begin
            sda_oe <= ~tx_byte_reg[7];
            tx_byte_reg <= {tx_byte_reg[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          // master nack ends the read; ack loads the next byte
          if (shift_reg[0]) begin
            state_reg <= ST_IDLE;
            sda_oe <= 1'b0;
          end else begin
            state_reg <= ST_RDATA;
            tx_byte_reg <= {rd_nxt[6:0], 1'b0};
            sda_oe <= ~rd_nxt[7];
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule : module_mgmt_two_wire_alarms
